// ==== core/ppf_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the pin block
`ifndef PPF_CFG_SVH
`define PPF_CFG_SVH

// Register byte addresses
`define PPF_ADDR_P1_LATCH 8'h00
`define PPF_ADDR_P3_LATCH 8'h04
`define PPF_ADDR_P4_LATCH 8'h08
`define PPF_ADDR_CTRL 8'h0c
`define PPF_ADDR_P1_PIN 8'h10
`define PPF_ADDR_P3_PIN 8'h14
`define PPF_ADDR_P4_PIN 8'h18
`define PPF_ADDR_P7_PIN 8'h1c
`define PPF_ADDR_STATUS 8'h20

// Reset values
`define PPF_LATCH_RST 8'hff
`define PPF_CTRL_RST 8'h00

// Control fields
`define PPF_CTRL_IDLE 0
`define PPF_CTRL_PDOWN 1
`define PPF_CTRL_SLOW 2
`define PPF_CTRL_SYSCLK_OUTPUT_PIN 3
`define PPF_CTRL_SERSYNC 4

// Status fields
`define PPF_STAT_STRAP 3
`define PPF_STAT_AUTOSTART 4
`define PPF_STAT_BLOCKED 5

// Synchroniser bit layout
`define PPF_SYNC_P1 0
`define PPF_SYNC_P3 8
`define PPF_SYNC_P4 16
`define PPF_SYNC_P7 24
`define PPF_SYNC_STRAP 32
`define PPF_SYNC_RSTPIN 33
`define PPF_SYNC_W 34

// AXI responses
`define PPF_RESP_OKAY 2'b00
`define PPF_RESP_SLVERR 2'b10

// Timing: machine cycle and system clock period
`define PPF_MCYCLE_NS 1000
`define PPF_CLK_NS 10
// Edges after bus reset until the synchroniser shows real pin levels
`define PPF_SYNC_FILL 4
`define PPF_MCYCLE_CLKS ((`PPF_MCYCLE_NS + `PPF_CLK_NS - 1) / `PPF_CLK_NS)

`endif

// ==== core/ppf_pkg.sv ====
// Types shared by the pin block
package ppf_pkg;

  // Reset qualifier states
  typedef enum logic {
    PPF_RST_HOLD,
    PPF_RST_RUN
  } ppf_rst_state_t;

  typedef logic [7:0] ppf_byte_t;

endpackage

// ==== core/ppf_sync_if.sv ====
// Raw and qualified pin levels between the top and its synchroniser
`timescale 1ns/10ps
`default_nettype none

interface ppf_sync_if #(parameter int W = 34);
  logic [W-1:0] raw;
  logic [W-1:0] clean;

  modport sync_side (input raw, output clean);
  modport user_side (output raw, input clean);
endinterface

`default_nettype wire

// ==== core/ppf_pin_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages agree
`timescale 1ns/10ps
`default_nettype none

module ppf_pin_sync #(
  parameter int W = 34,
  parameter logic [W-1:0] RST = '1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin levels
  ppf_sync_if.sync_side s
);

  logic [W-1:0] st1;
  logic [W-1:0] st2;
  logic [W-1:0] st3;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st1 <= RST;
      st2 <= RST;
      st3 <= RST;
    end
    else
    begin
      st1 <= s.raw;
      st2 <= st1;
      st3 <= st2;
    end
  end

  // Qualified level moves only where stages two and three agree
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s.clean <= RST;
    else
      s.clean <= (st2 & ~(st2 ^ st3)) | (s.clean & (st2 ^ st3));
  end

endmodule

`default_nettype wire

// ==== core/ppf_top.sv ====
// Port pins, alternate-function routing, reset qualifier and strap logic
`include "ppf_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ppf_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Quasi-bidirectional ports 1, 3 and 4
  input wire logic [7:0] p1_in,
  output logic [7:0] p1_out,
  output logic [7:0] p1_oe,
  output logic [7:0] p1_pullup,
  input wire logic [7:0] p3_in,
  output logic [7:0] p3_out,
  output logic [7:0] p3_oe,
  output logic [7:0] p3_pullup,
  input wire logic [7:0] p4_in,
  output logic [7:0] p4_out,
  output logic [7:0] p4_oe,
  output logic [7:0] p4_pullup,
  // Input-only port and control pins
  input wire logic [7:0] p7_in,
  input wire logic powersave_wdog_strap,
  input wire logic reset_pin_n,
  // Peripheral sources for alternate outputs
  input wire logic [7:0] cmp_out_ch,
  input wire logic [7:0] cmp_en,
  input wire logic [3:0] cc_cmp_out,
  input wire logic [3:0] cc_cmp_en,
  input wire logic sysclk_phase,
  input wire logic serial0_transmit,
  input wire logic ser0_sync_data_out,
  input wire logic xmem_wr_n,
  input wire logic xmem_rd_n,
  input wire logic verify_mode,
  input wire logic [7:0] verify_addr_lo,
  // Alternate inputs towards peripherals
  output logic irq3_capcmp0_pin,
  output logic irq4_capcmp1_pin,
  output logic irq5_capcmp2_pin,
  output logic irq6_capcmp3_pin,
  output logic timer2_reload_trigger,
  output logic timer2_count_input,
  output logic irq0_timer0_gate,
  output logic serial0_receive,
  output logic [7:0] p7_digital,
  // Reset, watchdog and power modes
  output logic chip_reset_n,
  output logic wdog_start,
  output logic wdog_autostart,
  output logic [2:0] pmode_grant
);

  localparam logic [7:0] MCYCLE_CLKS = 8'(`PPF_MCYCLE_CLKS);
  localparam logic [2:0] SYNC_FILL = 3'(`PPF_SYNC_FILL);

  ppf_pkg::ppf_rst_state_t rst_state;
  ppf_pkg::ppf_byte_t p1_latch;
  ppf_pkg::ppf_byte_t p3_latch;
  ppf_pkg::ppf_byte_t p4_latch;
  ppf_pkg::ppf_byte_t ctrl;
  ppf_pkg::ppf_byte_t next_p1;
  ppf_pkg::ppf_byte_t next_p3;
  ppf_pkg::ppf_byte_t next_p4;
  ppf_pkg::ppf_byte_t p1_push;
  ppf_pkg::ppf_byte_t p4_push;
  logic [7:0] low_cnt;
  logic [7:0] aw_addr;
  logic aw_got;
  logic [31:0] w_data;
  logic w_strb0;
  logic w_got;
  logic mode_blocked;
  logic [7:0] pin_p1;
  logic [7:0] pin_p3;
  logic [7:0] pin_p4;
  logic strap_lvl;
  logic rst_pin_lvl;
  logic [2:0] warm_cnt;
  logic fill_done;
  logic [32:0] rd_look;
  logic [32:0] wr_look;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Pin synchroniser
  ppf_sync_if #(.W(`PPF_SYNC_W)) pins ();

  assign pins.raw = {reset_pin_n, powersave_wdog_strap, p7_in, p4_in,
                     p3_in, p1_in};

  ppf_pin_sync #(.W(`PPF_SYNC_W)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .s(pins.sync_side)
  );

  assign pin_p1 = pins.clean[`PPF_SYNC_P1 +: 8];
  assign pin_p3 = pins.clean[`PPF_SYNC_P3 +: 8];
  assign pin_p4 = pins.clean[`PPF_SYNC_P4 +: 8];
  assign strap_lvl = pins.clean[`PPF_SYNC_STRAP];
  assign rst_pin_lvl = pins.clean[`PPF_SYNC_RSTPIN];

  // Returns {out, oe, pullup}: pushed pins drive both levels
  function automatic logic [2:0] pin_drive(input logic val,
                                           input logic push);
    pin_drive = {val, push | ~val, val & ~push};
  endfunction

  // Register read map; bit 32 flags a mapped address
  function automatic logic [32:0] read_map(input logic [7:0] a);
    read_map = {1'b1, 32'h0000_0000};
    case (a)
      `PPF_ADDR_P1_LATCH: read_map[7:0] = p1_latch;
      `PPF_ADDR_P3_LATCH: read_map[7:0] = p3_latch;
      `PPF_ADDR_P4_LATCH: read_map[7:0] = p4_latch;
      `PPF_ADDR_CTRL: read_map[7:0] = ctrl;
      `PPF_ADDR_P1_PIN: read_map[7:0] = pin_p1;
      `PPF_ADDR_P3_PIN: read_map[7:0] = pin_p3;
      `PPF_ADDR_P4_PIN: read_map[7:0] = pin_p4;
      `PPF_ADDR_P7_PIN: read_map[7:0] = p7_digital;
      `PPF_ADDR_STATUS: read_map[7:0] = {2'b00, mode_blocked,
                                         wdog_autostart, strap_lvl,
                                         pmode_grant};
      default: read_map[32] = 1'b0;
    endcase
  endfunction

  // Map lookups for the read and the write address
  always_comb
  begin
    rd_look = read_map(araddr);
    wr_look = read_map(aw_addr);
  end

  // Holds off the reset release and the watchdog start pulse until the synchroniser is filled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      warm_cnt <= 3'h0;
    else if (warm_cnt != SYNC_FILL)
      warm_cnt <= warm_cnt + 3'h1;
  end

  assign fill_done = (warm_cnt == SYNC_FILL);

  // Reset qualifier: low for a machine cycle enters hold
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rst_state <= ppf_pkg::PPF_RST_HOLD;
      low_cnt <= 8'h00;
      chip_reset_n <= 1'b0;
    end
    else
    begin
      case (rst_state)
        ppf_pkg::PPF_RST_HOLD:
        begin
          low_cnt <= 8'h00;
          if (rst_pin_lvl && fill_done)
          begin
            rst_state <= ppf_pkg::PPF_RST_RUN;
            chip_reset_n <= 1'b1;
          end
        end
        ppf_pkg::PPF_RST_RUN:
        begin
          if (rst_pin_lvl)
            low_cnt <= 8'h00;
          else if (low_cnt == MCYCLE_CLKS - 8'h01)
          begin
            rst_state <= ppf_pkg::PPF_RST_HOLD;
            chip_reset_n <= 1'b0;
            low_cnt <= 8'h00;
          end
          else
            low_cnt <= low_cnt + 8'h01;
        end
        default:
        begin
          rst_state <= ppf_pkg::PPF_RST_HOLD;
          chip_reset_n <= 1'b0;
        end
      endcase
    end
  end

  // Strap capture during reset and watchdog start pulse at release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wdog_autostart <= 1'b0;
      wdog_start <= 1'b0;
    end
    else
    begin
      wdog_start <= 1'b0;
      if (rst_state == ppf_pkg::PPF_RST_HOLD)
      begin
        wdog_autostart <= strap_lvl;
        wdog_start <= rst_pin_lvl & strap_lvl & fill_done;
      end
    end
  end

  // Power-saving requests pass only while the strap is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pmode_grant <= 3'b000;
      mode_blocked <= 1'b0;
    end
    else
    begin
      pmode_grant <= ctrl[2:0] & {3{~strap_lvl}};
      mode_blocked <= (|ctrl[2:0]) & strap_lvl;
    end
  end

  // Write channel capture, register update and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `PPF_RESP_OKAY;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_addr <= awaddr;
        aw_got <= 1'b1;
        awready <= 1'b0;
      end
      else if (!aw_got && !bvalid)
        awready <= 1'b1;
      if (wvalid && wready)
      begin
        w_data <= wdata;
        w_strb0 <= wstrb[0];
        w_got <= 1'b1;
        wready <= 1'b0;
      end
      else if (!w_got && !bvalid)
        wready <= 1'b1;
      if (aw_got && w_got && !bvalid)
      begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_look[32] ? `PPF_RESP_OKAY : `PPF_RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  // Port latches set to all ones and control cleared, by either reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !chip_reset_n)
    begin
      p1_latch <= `PPF_LATCH_RST;
      p3_latch <= `PPF_LATCH_RST;
      p4_latch <= `PPF_LATCH_RST;
      ctrl <= `PPF_CTRL_RST;
    end
    else if (aw_got && w_got && !bvalid && w_strb0)
    begin
      case (aw_addr)
        `PPF_ADDR_P1_LATCH: p1_latch <= w_data[7:0];
        `PPF_ADDR_P3_LATCH: p3_latch <= w_data[7:0];
        `PPF_ADDR_P4_LATCH: p4_latch <= w_data[7:0];
        `PPF_ADDR_CTRL: ctrl <= {3'b000, w_data[4:0]};
        default: ;
      endcase
    end
  end

  // Read channel: data registered at the address handshake
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `PPF_RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_look[31:0];
      rresp <= rd_look[32] ? `PPF_RESP_OKAY : `PPF_RESP_SLVERR;
    end
    else if (rvalid && rready)
      rvalid <= 1'b0;
    else if (!rvalid)
      arready <= 1'b1;
  end

  // Pin values from latches and alternate sources
  always_comb
  begin
    next_p1 = p1_latch;
    p1_push = {4'h0, cc_cmp_en};
    for (int i = 0; i < 4; i++)
    begin
      if (cc_cmp_en[i])
        next_p1[i] = cc_cmp_out[i];
    end
    if (ctrl[`PPF_CTRL_SYSCLK_OUTPUT_PIN])
      next_p1[6] = p1_latch[6] & sysclk_phase;
    if (verify_mode)
    begin
      next_p1 = verify_addr_lo;
      p1_push = 8'h00;
    end
    next_p3 = p3_latch;
    if (ctrl[`PPF_CTRL_SERSYNC])
      next_p3[0] = p3_latch[0] & ser0_sync_data_out;
    next_p3[1] = p3_latch[1] & serial0_transmit;
    next_p3[6] = p3_latch[6] & xmem_wr_n;
    next_p3[7] = p3_latch[7] & xmem_rd_n;
    next_p4 = (cmp_en & cmp_out_ch) | (~cmp_en & p4_latch);
    p4_push = cmp_en;
  end

  // Registered pin drivers; unpushed ones at one leave a weak pull-up, at zero drive low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      p1_out <= 8'hff;
      p1_oe <= 8'h00;
      p1_pullup <= 8'hff;
      p3_out <= 8'hff;
      p3_oe <= 8'h00;
      p3_pullup <= 8'hff;
      p4_out <= 8'hff;
      p4_oe <= 8'h00;
      p4_pullup <= 8'hff;
    end
    else
    begin
      for (int i = 0; i < 8; i++)
      begin
        {p1_out[i], p1_oe[i], p1_pullup[i]} <=
          pin_drive(next_p1[i], p1_push[i]);
        {p3_out[i], p3_oe[i], p3_pullup[i]} <=
          pin_drive(next_p3[i], 1'b0);
        {p4_out[i], p4_oe[i], p4_pullup[i]} <=
          pin_drive(next_p4[i], p4_push[i]);
      end
    end
  end

  // Alternate inputs sampled from the qualified pin levels
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      {irq6_capcmp3_pin, irq5_capcmp2_pin} <= 2'b11;
      {irq4_capcmp1_pin, irq3_capcmp0_pin} <= 2'b11;
      timer2_reload_trigger <= 1'b1;
      timer2_count_input <= 1'b1;
      irq0_timer0_gate <= 1'b1;
      serial0_receive <= 1'b1;
      p7_digital <= 8'hff;
    end
    else
    begin
      {irq6_capcmp3_pin, irq5_capcmp2_pin} <= pin_p1[3:2];
      {irq4_capcmp1_pin, irq3_capcmp0_pin} <= pin_p1[1:0];
      timer2_reload_trigger <= pin_p1[5];
      timer2_count_input <= pin_p1[7];
      irq0_timer0_gate <= pin_p3[2];
      serial0_receive <= pin_p3[0];
      p7_digital <= pins.clean[`PPF_SYNC_P7 +: 8];
    end
  end

  // Checks
  chk_strap_blocks_modes: assert property (
    strap_lvl |=> pmode_grant == 3'b000)
    else $error("power mode granted while strap high");

  chk_strap_low_grants: assert property (
    !strap_lvl |=> pmode_grant == $past(ctrl[2:0]))
    else $error("power mode request not granted with strap low");

  chk_wdog_auto_start: assert property (
    $rose(chip_reset_n) |-> wdog_start == wdog_autostart)
    else $error("watchdog start does not follow captured strap");

  chk_wdog_stays_off: assert property (
    $rose(chip_reset_n) && !wdog_autostart |-> !wdog_start ##1 !wdog_start)
    else $error("watchdog started with strap low in reset");

  chk_reset_not_early: assert property (
    $fell(chip_reset_n) && $past(rst_state) == ppf_pkg::PPF_RST_RUN
      |-> $past(low_cnt) == MCYCLE_CLKS - 8'h01)
    else $error("reset taken before a full machine cycle");

  chk_reset_after_cycle: assert property (
    chip_reset_n && !rst_pin_lvl && low_cnt == MCYCLE_CLKS - 8'h01
      |=> !chip_reset_n ##1 p1_latch == `PPF_LATCH_RST)
    else $error("machine-cycle low reset not applied");

  chk_cmp_drives_p4: assert property (
    cmp_en != 8'h00 |=>
      (((p4_out ^ $past(cmp_out_ch)) | ~p4_oe) & $past(cmp_en)) == 8'h00)
    else $error("compare channel not driving its pin");

  chk_quasi_weak_high: assert property (
    !cmp_en[7] && p4_latch[7] |=> p4_pullup[7] && !p4_oe[7])
    else $error("latched one is not a weak high");

  chk_verify_address: assert property (
    verify_mode |=> p1_out == $past(verify_addr_lo))
    else $error("verify address missing on port 1");

  chk_txd_route: assert property (
    p3_latch[1] |=> p3_out[1] == $past(serial0_transmit))
    else $error("transmit data not on port 3 bit 1");

endmodule

`default_nettype wire

// ==== verification/ppf_board.sv ====
// Board model: resolves each quasi pin against external drivers
`timescale 1ns/10ps
`default_nettype none

module ppf_board (
  // Device side of the pin
  input wire logic [7:0] dout,
  input wire logic [7:0] oe,
  input wire logic [7:0] weak_up,
  // External driver on the board
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  // Resolved pin level
  output logic [7:0] pin
);
  // Strong drive wins, then the board driver, then the weak pull-up
  assign pin = (oe & dout) | (~oe & ext_en & ext_val)
    | (~oe & ~ext_en & weak_up);
endmodule

`default_nettype wire

// ==== verification/ppf_top_test.sv ====
// Self-checking bench of the port pin block with a board model
`include "ppf_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module ppf_top_test;
  // Result counters and the one comparison
  int err_count = 0;
  int tests_run = 0;
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

  // Bench-driven inputs
  logic aclk = 0, aresetn = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0;
  logic [3:0] wstrb = 0;
  logic [7:0] p7_in = 0, cmp_out_ch = 0, cmp_en = 0, verify_addr_lo = 0;
  logic [7:0] e1_en = 0, e1_v = 0, e3_en = 0, e3_v = 0;
  logic powersave_wdog_strap = 0, reset_pin_n = 1, verify_mode = 0;
  logic serial0_transmit = 1, xmem_wr_n = 1, xmem_rd_n = 1;
  // Design outputs and pins
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] p1_in, p1_out, p1_oe, p1_pullup, p3_in, p3_out, p3_oe;
  logic [7:0] p3_pullup, p4_in, p4_out, p4_oe, p4_pullup, p7_digital;
  logic irq3_capcmp0_pin, irq4_capcmp1_pin, irq5_capcmp2_pin;
  logic irq6_capcmp3_pin, timer2_reload_trigger, timer2_count_input;
  logic irq0_timer0_gate, serial0_receive, chip_reset_n;
  logic wdog_start, wdog_autostart;
  logic [2:0] pmode_grant;
  // Model state
  logic [7:0] l1, l3, l4, ce, co, v1, v3, pin1, pin3, va, cf;
  logic [3:0] pe, po, cc_en = 0, cc_out = 0;
  logic sp = 1, sd = 1;
  logic seen;
  int i;

  // Free-running 100 MHz clock
  initial forever #5 aclk = ~aclk;

  ppf_top ppf_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .p1_in, .p1_out,
    .p1_oe, .p1_pullup, .p3_in, .p3_out, .p3_oe, .p3_pullup, .p4_in,
    .p4_out, .p4_oe, .p4_pullup, .p7_in, .powersave_wdog_strap,
    .reset_pin_n, .cmp_out_ch, .cmp_en, .cc_cmp_out(cc_out),
    .cc_cmp_en(cc_en), .sysclk_phase(sp), .serial0_transmit,
    .ser0_sync_data_out(sd), .xmem_wr_n, .xmem_rd_n, .verify_mode,
    .verify_addr_lo, .irq3_capcmp0_pin, .irq4_capcmp1_pin,
    .irq5_capcmp2_pin, .irq6_capcmp3_pin, .timer2_reload_trigger,
    .timer2_count_input, .irq0_timer0_gate, .serial0_receive, .p7_digital,
    .chip_reset_n, .wdog_start, .wdog_autostart, .pmode_grant);

  // One board model for each quasi port
  ppf_board b1_inst (.dout(p1_out), .oe(p1_oe), .weak_up(p1_pullup),
    .ext_en(e1_en), .ext_val(e1_v), .pin(p1_in));
  ppf_board b3_inst (.dout(p3_out), .oe(p3_oe), .weak_up(p3_pullup),
    .ext_en(e3_en), .ext_val(e3_v), .pin(p3_in));
  ppf_board b4_inst (.dout(p4_out), .oe(p4_oe), .weak_up(p4_pullup),
    .ext_en(8'h00), .ext_val(8'h00), .pin(p4_in));

  // Counts, verdict and end of run
  task automatic results(input bit timed_out);
    if (timed_out)
      err_count++;
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // AXI4-Lite write, response code compared
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    if (n == 50) results(1);
    `CHK(bresp, er)
  endtask

  // AXI4-Lite read, data and response compared
  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input logic [1:0] er);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    if (n == 50) results(1);
    `CHK(rdata, {24'h00_0000, e})
    `CHK(rresp, er)
  endtask

  // Quasi pin drive compared with the expected triple
  task automatic chkp(input logic [7:0] o, oe, pu, eo, eoe, epu);
    `CHK(o, eo)
    `CHK(oe, eoe)
    `CHK(pu, epu)
  endtask

  // Pin sync takes four edges; leave margin for the drive edge
  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask

  // Waits for the qualified reset to lift, noting a watchdog pulse
  task automatic wait_run;
    seen = 1'b0;
    for (i = 0; i < 40; i++)
    begin
      @(posedge aclk);
      #1;
      seen = seen | (wdog_start === 1'b1);
      if (chip_reset_n === 1'b1) break;
    end
    if (i == 40) results(1);
  endtask

  // Main sequence
  initial
  begin
    void'($urandom(12988));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    wait_run();
    `CHK(seen, 1'b0)
    `CHK(wdog_autostart, 1'b0)
    rdc(8'h00, 8'hff, `PPF_RESP_OKAY);
    rdc(8'h04, 8'hff, `PPF_RESP_OKAY);
    rdc(8'h08, 8'hff, `PPF_RESP_OKAY);
    rdc(8'h0c, 8'h00, `PPF_RESP_OKAY);
    rdc(8'h24, 8'h00, `PPF_RESP_SLVERR);
    wr(8'h24, 8'h00, `PPF_RESP_SLVERR);
    // Random latches, compare pushes, strobes and board drive
    repeat (6)
    begin
      l1 = $urandom;
      l3 = $urandom;
      l4 = $urandom;
      ce = $urandom;
      co = $urandom;
      cf = $urandom & 32'h0000_0018;
      pe = 4'($urandom);
      po = 4'($urandom);
      wr(8'h00, l1, `PPF_RESP_OKAY);
      wr(8'h04, l3, `PPF_RESP_OKAY);
      wr(8'h08, l4, `PPF_RESP_OKAY);
      wr(8'h0c, cf, `PPF_RESP_OKAY);
      @(posedge aclk);
      cmp_en <= ce;
      cmp_out_ch <= co;
      cc_en <= pe;
      cc_out <= po;
      {sp, sd, xmem_rd_n, xmem_wr_n, serial0_transmit} <= 5'($urandom);
      p7_in <= $urandom;
      e1_en <= l1 & ~{4'h0, pe} & 8'($urandom);
      e1_v <= $urandom;
      e3_en <= l3 & 8'($urandom);
      e3_v <= $urandom;
      settle();
      // Pushed capture/compare bits, clock gate on bit 6, sync data on 0
      v1 = l1;
      v1[3:0] = (pe & po) | (~pe & l1[3:0]);
      v1[6] = l1[6] & (~cf[3] | sp);
      v3 = l3 & {xmem_rd_n, xmem_wr_n, 4'hf, serial0_transmit, ~cf[4] | sd};
      pin1 = v1 & (~e1_en | e1_v);
      pin3 = v3 & (~e3_en | e3_v);
      chkp(p1_out, p1_oe, p1_pullup, v1, {4'h0, pe} | ~v1,
           ~{4'h0, pe} & v1);
      chkp(p3_out, p3_oe, p3_pullup, v3, ~v3, v3);
      chkp(p4_out, p4_oe, p4_pullup, (ce & co) | (~ce & l4), ce | ~l4,
           ~ce & l4);
      `CHK({irq6_capcmp3_pin, irq5_capcmp2_pin, irq4_capcmp1_pin,
            irq3_capcmp0_pin}, pin1[3:0])
      `CHK(timer2_reload_trigger, pin1[5])
      `CHK(timer2_count_input, pin1[7])
      `CHK({irq0_timer0_gate, serial0_receive}, {pin3[2], pin3[0]})
      `CHK(p7_digital, p7_in)
      rdc(8'h10, pin1, `PPF_RESP_OKAY);
      rdc(8'h14, pin3, `PPF_RESP_OKAY);
      rdc(8'h18, (ce & co) | (~ce & l4), `PPF_RESP_OKAY);
      rdc(8'h1c, p7_in, `PPF_RESP_OKAY);
    end
    // Program verification shows the address byte on port 1
    va = $urandom;
    @(posedge aclk);
    verify_mode <= 1'b1;
    verify_addr_lo <= va;
    settle();
    chkp(p1_out, p1_oe, p1_pullup, va, ~va, va);
    verify_mode <= 1'b0;
    // Strap gating of the power-saving requests
    wr(8'h0c, 8'h07, `PPF_RESP_OKAY);
    settle();
    `CHK(pmode_grant, 3'b111)
    rdc(8'h20, 8'h07, `PPF_RESP_OKAY);
    powersave_wdog_strap <= 1'b1;
    settle();
    `CHK(pmode_grant, 3'b000)
    rdc(8'h20, 8'h28, `PPF_RESP_OKAY);
    // Reset pin: a short pulse is ignored, a machine cycle resets
    wr(8'h00, 8'h5a, `PPF_RESP_OKAY);
    reset_pin_n <= 1'b0;
    repeat (60) @(posedge aclk);
    reset_pin_n <= 1'b1;
    repeat (10) @(posedge aclk);
    `CHK(chip_reset_n, 1'b1)
    rdc(8'h00, 8'h5a, `PPF_RESP_OKAY);
    reset_pin_n <= 1'b0;
    repeat (120) @(posedge aclk);
    `CHK(chip_reset_n, 1'b0)
    rdc(8'h00, 8'hff, `PPF_RESP_OKAY);
    reset_pin_n <= 1'b1;
    wait_run();
    `CHK(seen, 1'b1)
    `CHK(wdog_autostart, 1'b1)
    results(0);
  end
endmodule

`default_nettype wire
